// ===== shared/rot_ret_pkg.sv
// package: constants and types for the rotate and return execution block
`default_nettype none
package rot_ret_pkg;
	localparam int                 DATA_W      = 8;
	localparam int                 SP_W        = 6;
	localparam int                 PC_W        = 20;
	localparam int                 REG_SEL_W   = 4;
	localparam int                 NUM_REGS    = 16;
	localparam int                 STACK_DEPTH = 64;
	localparam logic [SP_W-1:0]    RETURN_POP  = 6'h02;
	localparam logic [SP_W-1:0]    SP_RESET    = 6'h00;
	localparam logic [PC_W-1:0]    PC_RESET    = 20'h00000;
	localparam logic [DATA_W-1:0]  REG_RESET   = 8'h00;
	localparam int                 MSB_POS     = 7;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_RETURN,
		OP_ROTATE_LEFT,
		OP_ROTATE_LEFT_CARRY
	} exec_op_t;

	typedef struct packed {
		exec_op_t                 op;
		logic [REG_SEL_W-1:0]     reg_sel;
	} exec_cmd_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic negative;
	} flags_t;

	typedef struct packed {
		logic                     wr_en;
		logic [SP_W-1:0]          addr;
		logic [PC_W-1:0]          data;
	} stack_write_t;
endpackage : rot_ret_pkg
`default_nettype wire

// ===== verilog/hardware_stack_mem.sv
// hardware stack storage with registered read data
`default_nettype none
module hardware_stack_mem
	import rot_ret_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             clk_en,
	input  wire stack_write_t     wr,
	input  wire logic [SP_W-1:0]  rd_addr,
	output var  logic [PC_W-1:0]  rd_data
);
	logic [PC_W-1:0] mem [STACK_DEPTH];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge sys_clk) begin
		if (clk_en && wr.wr_en) begin
			mem[wr.addr] <= wr.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : hardware_stack_mem
`default_nettype wire

// ===== verilog/rotate_and_return_exec.sv
// execution of return from subroutine, rotate left and rotate left through carry
// Operation
// - A return loads the program counter from stack entry pointer minus two, then drops the pointer by two.
// - The hardware stack pointer is a six-bit counter indexing the stack entries.
// - Rotate left shifts the register up one place, old bit 7 into bit 0 and into carry.
// - After rotate left, zero flags a zero byte and negative copies the new top bit.
// - Rotate left through carry shifts up, old carry into bit 0, old bit 7 into carry.
// - After rotate left through carry, carry is old bit 7, zero a zero result, negative new bit 7.
// - Each rotate sets zero from its own 8-bit result only, never a chained 16-bit value.
`default_nettype none
module rotate_and_return_exec
	import rot_ret_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic                  cmd_valid,
	input  wire exec_cmd_t             cmd,
	input  wire stack_write_t          stack_wr,
	input  wire logic                  reg_wr_en,
	input  wire logic [REG_SEL_W-1:0]  reg_wr_sel,
	input  wire logic [DATA_W-1:0]     reg_wr_data,
	input  wire logic                  sp_load,
	input  wire logic [SP_W-1:0]       sp_load_val,
	output var  logic [PC_W-1:0]       pc_reg,
	output var  logic                  pc_load_reg,
	output var  logic [SP_W-1:0]       sp_reg,
	output var  flags_t                flags_reg,
	output var  logic                  busy_reg,
	output var  logic [DATA_W-1:0]     result_reg
);
	logic [DATA_W-1:0]  general_register [NUM_REGS];
	logic [PC_W-1:0]    stack_rd_data;
	logic [SP_W-1:0]    stack_rd_addr;
	logic               return_pending_reg;
	logic [DATA_W-1:0]  operand;
	logic [DATA_W-1:0]  rot_next;
	logic               carry_next;
	logic               rot_fire;

	// stack read at pointer minus two each enabled cycle: the read data arrive a cycle later
	// read every enabled cycle, so the entry is already in flight when a return is taken
	assign stack_rd_addr = SP_W'(sp_reg - RETURN_POP);

	hardware_stack_mem u_stack (
		.sys_clk (sys_clk),
		.clk_en  (clk_en),
		.wr      (stack_wr),
		.rd_addr (stack_rd_addr),
		.rd_data (stack_rd_data)
	);

	assign operand  = general_register[cmd.reg_sel];
	assign rot_fire = cmd_valid && !busy_reg &&
		(cmd.op == OP_ROTATE_LEFT || cmd.op == OP_ROTATE_LEFT_CARRY);

	always_comb begin
		case (cmd.op)
			OP_ROTATE_LEFT: begin
				rot_next   = {operand[MSB_POS-1:0], operand[MSB_POS]};
				carry_next = operand[MSB_POS];
			end
			OP_ROTATE_LEFT_CARRY: begin
				rot_next   = {operand[MSB_POS-1:0], flags_reg.carry};
				carry_next = operand[MSB_POS];
			end
			default: begin
				rot_next   = operand;
				carry_next = flags_reg.carry;
			end
		endcase
	end

	// register file; a rotate wins over an outside write to the same register in the same cycle
	generate
		for (genvar i = 0; i < NUM_REGS; i++) begin : g_regs
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					general_register[i] <= REG_RESET;
				end else if (clk_en) begin
					if (rot_fire && cmd.reg_sel == REG_SEL_W'(i)) begin
						general_register[i] <= rot_next;
					end else if (reg_wr_en && reg_wr_sel == REG_SEL_W'(i)) begin
						general_register[i] <= reg_wr_data;
					end
				end
			end
		end
	endgenerate

	// flags come from this byte alone, so chained rotates leave zero per byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_reg  <= '0;
			result_reg <= REG_RESET;
		end else if (clk_en && rot_fire) begin
			flags_reg.carry    <= carry_next;
			flags_reg.zero     <= (rot_next == '0);
			flags_reg.negative <= rot_next[MSB_POS];
			result_reg         <= rot_next;
		end
	end

	// return takes two cycles because stack read data are registered
	// busy drops any command in the cycle after a return is taken
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			return_pending_reg <= 1'b0;
			busy_reg           <= 1'b0;
		end else if (clk_en) begin
			return_pending_reg <= cmd_valid && !busy_reg && cmd.op == OP_RETURN;
			busy_reg           <= cmd_valid && !busy_reg && cmd.op == OP_RETURN;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pc_reg      <= PC_RESET;
			pc_load_reg <= 1'b0;
		end else if (clk_en) begin
			pc_load_reg <= return_pending_reg;
			if (return_pending_reg) begin
				pc_reg <= stack_rd_data;
			end
		end
	end

	// six-bit pointer wraps modulo 64
	// a pointer load on the edge a return moves the pointer is lost
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sp_reg <= SP_RESET;
		end else if (clk_en) begin
			if (return_pending_reg) begin
				sp_reg <= SP_W'(sp_reg - RETURN_POP);
			end else if (sp_load) begin
				sp_reg <= sp_load_val;
			end
		end
	end

	// return path: taken, one busy cycle, then program counter and pointer move
	sequence s_return_issue;
		clk_en && cmd_valid && !busy_reg && cmd.op == OP_RETURN;
	endsequence

	sequence s_return_wait;
		clk_en && busy_reg;
	endsequence

	a_return_busy: assert property (@(posedge sys_clk) disable iff (rst)
		s_return_issue |=> busy_reg && return_pending_reg)
		else $error("return not held busy for its stack read");

	a_return_sp_drop: assert property (@(posedge sys_clk) disable iff (rst)
		s_return_issue ##1 s_return_wait |=> sp_reg == SP_W'($past(sp_reg) - RETURN_POP))
		else $error("stack pointer not reduced by two after return");

	a_return_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		s_return_issue ##1 s_return_wait |=> pc_load_reg && !busy_reg)
		else $error("program counter load pulse missing after return");

	a_return_pc_load: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && return_pending_reg) |=> pc_load_reg && pc_reg == $past(stack_rd_data))
		else $error("program counter not loaded from stack on return");

	// busy lasts one enabled cycle and swallows whatever is offered in it
	a_busy_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && busy_reg) |=> !busy_reg)
		else $error("busy held longer than one cycle");

	a_busy_refuse: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && busy_reg) |=> $stable(result_reg) && $stable(flags_reg))
		else $error("command acted on while busy");

	// pointer moves only by a return or a load
	a_sp_stable: assert property (@(posedge sys_clk) disable iff (rst)
		(!return_pending_reg && !sp_load) |=> $stable(sp_reg))
		else $error("stack pointer moved without cause");

	a_sp_load: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && sp_load && !return_pending_reg) |=> sp_reg == $past(sp_load_val))
		else $error("stack pointer load not taken");

	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!clk_en |=> $stable(pc_reg) && $stable(sp_reg) && $stable(busy_reg) &&
		$stable(flags_reg) && $stable(result_reg) && $stable(pc_load_reg))
		else $error("state moved while clock enable low");

	// rotate path: result, write-back and flags all come from the same byte
	a_rotate_data: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire && cmd.op == OP_ROTATE_LEFT) |=>
		result_reg == {$past(operand[6:0]), $past(operand[7])})
		else $error("rotate left result wrong");

	a_rotate_carry: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire && cmd.op == OP_ROTATE_LEFT) |=> flags_reg.carry == $past(operand[7]))
		else $error("rotate left carry wrong");

	a_rotate_writeback: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire) |=> general_register[$past(cmd.reg_sel)] == result_reg)
		else $error("rotate result not written back");

	a_rotate_flags: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire) |=>
		flags_reg.zero == (result_reg == 8'h00) && flags_reg.negative == result_reg[7])
		else $error("rotate zero or negative flag wrong");

	a_no_op_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && cmd_valid && cmd.op == OP_NONE) |=> $stable(result_reg) && $stable(flags_reg))
		else $error("empty command changed result or flags");

	a_carry_rot_data: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire && cmd.op == OP_ROTATE_LEFT_CARRY) |=>
		result_reg == {$past(operand[6:0]), $past(flags_reg.carry)})
		else $error("rotate through carry result wrong");

	a_carry_rot_flag: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire && cmd.op == OP_ROTATE_LEFT_CARRY) |=>
		flags_reg.carry == $past(operand[7]))
		else $error("rotate through carry flag wrong");

	// a chained pair cannot set zero from the other byte
	a_zero_byte: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rot_fire && rot_next != 8'h00) |=> !flags_reg.zero)
		else $error("zero flag set for nonzero byte");
endmodule : rotate_and_return_exec
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the rotate and return execution block
`default_nettype none
module tb_top
	import rot_ret_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic                 sys_clk     = 1'b0;
	logic                 rst         = 1'b1;
	logic                 clk_en      = 1'b1;
	logic                 cmd_valid   = 1'b0;
	exec_cmd_t            cmd         = '{OP_NONE, 4'h0};
	stack_write_t         stack_wr    = '0;
	logic                 reg_wr_en   = 1'b0;
	logic [REG_SEL_W-1:0] reg_wr_sel  = 4'h0;
	logic [DATA_W-1:0]    reg_wr_data = 8'h00;
	logic                 sp_load     = 1'b0;
	logic [SP_W-1:0]      sp_load_val = 6'h00;
	logic [PC_W-1:0]      pc_reg;
	logic                 pc_load_reg;
	logic [SP_W-1:0]      sp_reg;
	flags_t               flags_reg;
	logic                 busy_reg;
	logic [DATA_W-1:0]    result_reg;
	int                   n_errors    = 0;
	int                   n_tests     = 0;

	rotate_and_return_exec dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd(cmd), .stack_wr(stack_wr), .reg_wr_en(reg_wr_en),
		.reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .sp_load(sp_load),
		.sp_load_val(sp_load_val), .pc_reg(pc_reg), .pc_load_reg(pc_load_reg),
		.sp_reg(sp_reg), .flags_reg(flags_reg), .busy_reg(busy_reg),
		.result_reg(result_reg));

	always #4 sys_clk = ~sys_clk;

	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// commands are taken one edge after they are driven
	task automatic issue(input exec_op_t op, input logic [REG_SEL_W-1:0] sel);
		@(posedge sys_clk) cmd_valid <= 1'b1;
		cmd <= '{op, sel};
		@(posedge sys_clk) cmd_valid <= 1'b0;
		#1;
	endtask : issue

	task automatic wreg(input logic [REG_SEL_W-1:0] sel, input logic [DATA_W-1:0] d);
		@(posedge sys_clk) reg_wr_en <= 1'b1;
		reg_wr_sel <= sel;
		reg_wr_data <= d;
		@(posedge sys_clk) reg_wr_en <= 1'b0;
	endtask : wreg

	task automatic rot(input exec_op_t op, input logic [REG_SEL_W-1:0] sel,
		input logic [DATA_W-1:0] er, input logic [2:0] ef);
		issue(op, sel);
		chk(PC_W'(result_reg), PC_W'(er));
		chk(PC_W'(flags_reg), PC_W'(ef));
	endtask : rot

	// pointer a, entry sp (two below a) holds d; a rotate held into the busy cycle is dropped
	task automatic t_return(input logic [SP_W-1:0] a, input logic [PC_W-1:0] d,
		input logic [SP_W-1:0] sp);
		@(posedge sys_clk) stack_wr <= '{1'b1, sp, d};
		@(posedge sys_clk) stack_wr <= '{1'b1, a, ~d};
		@(posedge sys_clk) stack_wr.wr_en <= 1'b0;
		sp_load <= 1'b1;
		sp_load_val <= a;
		@(posedge sys_clk) sp_load <= 1'b0;
		@(posedge sys_clk) cmd_valid <= 1'b1;
		cmd <= '{OP_RETURN, 4'h0};
		@(posedge sys_clk) cmd <= '{OP_ROTATE_LEFT, 4'h0};
		#1;
		chk(PC_W'(busy_reg), 20'h00001);
		@(posedge sys_clk) cmd_valid <= 1'b0;
		#1;
		chk(pc_reg, d);
		chk(PC_W'(pc_load_reg), 20'h00001);
		chk(PC_W'(sp_reg), PC_W'(sp));
		// last rotate left of 81 still stands: the refused rotate left no mark
		chk(PC_W'(result_reg), 20'h00003);
		chk(PC_W'(flags_reg), 20'h00004);
		@(posedge sys_clk) #1;
		chk(PC_W'(pc_load_reg), 20'h00000);
	endtask : t_return

	task automatic t_reset();
		chk(pc_reg, PC_RESET);
		chk(PC_W'(sp_reg), PC_W'(SP_RESET));
		chk(PC_W'({busy_reg, pc_load_reg, flags_reg}), 20'h00000);
	endtask : t_reset

	task automatic t_rotate_left();
		wreg(4'h0, 8'h4A);
		rot(OP_ROTATE_LEFT, 4'h0, 8'h94, 3'h1);
		rot(OP_ROTATE_LEFT, 4'h0, 8'h29, 3'h4);
		wreg(4'h3, 8'h00);
		rot(OP_ROTATE_LEFT, 4'h3, 8'h00, 3'h2);
	endtask : t_rotate_left

	task automatic t_rotate_carry();
		wreg(4'h2, 8'hA5);
		rot(OP_ROTATE_LEFT_CARRY, 4'h2, 8'h4A, 3'h4);
		rot(OP_ROTATE_LEFT_CARRY, 4'h2, 8'h95, 3'h1);
		// 16-bit pair 8001 becomes 0002: zero follows the high byte alone
		wreg(4'h4, 8'h01);
		wreg(4'h5, 8'h80);
		rot(OP_ROTATE_LEFT, 4'h4, 8'h02, 3'h0);
		rot(OP_ROTATE_LEFT_CARRY, 4'h5, 8'h00, 3'h6);
	endtask : t_rotate_carry

	// a command under a low clock enable leaves no trace, nor does an empty command
	task automatic t_freeze();
		wreg(4'h6, 8'h81);
		@(posedge sys_clk) clk_en <= 1'b0;
		issue(OP_ROTATE_LEFT, 4'h6);
		chk(PC_W'(result_reg), 20'h00000);
		chk(PC_W'(flags_reg), 20'h00006);
		@(posedge sys_clk) clk_en <= 1'b1;
		issue(OP_NONE, 4'h6);
		chk(PC_W'(flags_reg), 20'h00006);
		rot(OP_ROTATE_LEFT, 4'h6, 8'h03, 3'h4);
	endtask : t_freeze

	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_rotate_left();
		t_rotate_carry();
		t_freeze();
		t_return(6'h0A, 20'h00121, 6'h08);
		// pointer wraps below zero
		t_return(6'h01, 20'hABCDE, 6'h3F);
		complete_run();
	end

	initial begin
		// a clean run needs some 53 cycles; this is about twelve times that
		#5000;
		n_errors++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
